// >>> rcf_pkg.sv
// constants and types shared by the reset-cause flag logic
package rcf_pkg;
    // register map and flag layout
    localparam logic [19:0] RCF_FLAGS_ADDR   = 20'hfffa8;
    localparam int          RCF_BIT_TRAP     = 7;
    localparam int          RCF_BIT_WDOG     = 4;
    localparam int          RCF_BIT_PARITY   = 2;
    localparam int          RCF_BIT_BADACC   = 1;
    localparam int          RCF_BIT_PWRON    = 0;
    localparam logic [7:0]  RCF_FLAG_MASK    = 8'h97;
    localparam logic [7:0]  RCF_FLAGS_RESET  = 8'h00;
    // processor state after reset acknowledgment
    localparam logic [7:0]  RCF_STATUS_RESET = 8'h06;
    localparam logic [19:0] RCF_PC_RESET     = 20'h00000;
    localparam logic [7:0]  RCF_ILLEGAL_OP   = 8'hff;
    localparam logic [19:0] RCF_VEC_LO_ADDR  = 20'h00000;
    localparam logic [19:0] RCF_VEC_HI_ADDR  = 20'h00001;
    // timing: figures in ns, counts derived from the 100 MHz clock
    localparam int          RCF_CLK_MHZ      = 100;
    localparam int          RCF_HOLD_NS      = 200;
    localparam int          RCF_OSC_WAIT_NS  = 1000;
    localparam int          RCF_HOLD_CYC     =
        (RCF_HOLD_NS * RCF_CLK_MHZ + 999) / 1000;
    localparam int          RCF_OSC_WAIT_CYC =
        (RCF_OSC_WAIT_NS * RCF_CLK_MHZ + 999) / 1000;
    localparam int          RCF_CNT_W        = 8;
    // sequencer states
    typedef enum logic [3:0] {
        RCF_ST_RUN   = 4'h1,
        RCF_ST_HOLD  = 4'h2,
        RCF_ST_WAIT  = 4'h4,
        RCF_ST_FETCH = 4'h8
    } rcf_state_t;
    // vector fetch states
    typedef enum logic [3:0] {
        RCF_VF_IDLE = 4'h1,
        RCF_VF_LO   = 4'h2,
        RCF_VF_HI   = 4'h4,
        RCF_VF_DONE = 4'h8
    } rcf_vf_state_t;
endpackage : rcf_pkg

// >>> rcf_fetch_if.sv
// handshake between the reset sequencer and the vector fetcher
`timescale 1ns/1ps
interface rcf_fetch_if;
    logic        start;
    logic        done;
    logic [19:0] pc;
    modport core    (output start, input  done, input  pc);
    modport fetcher (input  start, output done, output pc);
endinterface : rcf_fetch_if

// >>> rcf_sync2.sv
// two-flop synchroniser for the external reset pin
`timescale 1ns/1ps
module rcf_sync2 (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic asyncIn,
    output logic      syncOut
);
    typedef struct packed {
        logic meta;
        logic stable;
    } rcf_sync_st_t;

    rcf_sync_st_t s_r;
    rcf_sync_st_t s_nxt;

    // first flop feeds only the second one
    always_comb begin
        s_nxt        = s_r;
        s_nxt.meta   = asyncIn;
        s_nxt.stable = s_r.meta;
    end

    // idle level is high: pin not asserted
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '{meta: 1'b1, stable: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign syncOut = s_r.stable;

    property p_sync_delay;
        @(posedge mclk) disable iff (!rst_n)
        ##2 (syncOut == $past(asyncIn, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("pin level not passed after two edges");
endmodule : rcf_sync2

// >>> rcf_vector_fetch.sv
// reads the two reset vector bytes and forms the start address
`timescale 1ns/1ps
module rcf_vector_fetch
    import rcf_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   rst_n,
    rcf_fetch_if.fetcher fif,
    output logic [19:0] codeAddr,
    output logic        codeRd,
    input  wire logic [7:0] codeData
);
    typedef struct packed {
        rcf_vf_state_t st;
        logic [19:0]   addr;
        logic          rd;
        logic [7:0]    lo;
        logic [19:0]   pc;
        logic          done;
    } rcf_vf_st_t;

    rcf_vf_st_t s_r;
    rcf_vf_st_t s_nxt;

    // code memory answers one cycle after the read strobe
    always_comb begin
        s_nxt      = s_r;
        s_nxt.rd   = 1'b0;
        s_nxt.done = 1'b0;
        case (s_r.st)
            RCF_VF_IDLE: begin
                if (fif.start) begin
                    s_nxt.st   = RCF_VF_LO;
                    s_nxt.rd   = 1'b1;
                    s_nxt.addr = RCF_VEC_LO_ADDR;
                end
            end
            RCF_VF_LO: begin
                s_nxt.st   = RCF_VF_HI;
                s_nxt.rd   = 1'b1;
                s_nxt.addr = RCF_VEC_HI_ADDR;
            end
            RCF_VF_HI: begin
                s_nxt.st = RCF_VF_DONE;
                s_nxt.lo = codeData;
            end
            RCF_VF_DONE: begin
                s_nxt.st   = RCF_VF_IDLE;
                s_nxt.pc   = {4'h0, codeData, s_r.lo};
                s_nxt.done = 1'b1;
            end
            default: s_nxt.st = RCF_VF_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '{st: RCF_VF_IDLE, addr: RCF_VEC_LO_ADDR, rd: 1'b0,
                     lo: 8'h00, pc: RCF_PC_RESET, done: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign codeAddr = s_r.addr;
    assign codeRd   = s_r.rd;
    assign fif.pc   = s_r.pc;
    assign fif.done = s_r.done;

    sequence s_two_reads;
        (codeRd && codeAddr == RCF_VEC_LO_ADDR)
        ##1 (codeRd && codeAddr == RCF_VEC_HI_ADDR);
    endsequence
    property p_vector_order;
        @(posedge mclk) disable iff (!rst_n)
        (s_r.st == RCF_VF_IDLE && fif.start) |=> s_two_reads ##2 fif.done;
    endproperty
    a_vector_order: assert property (p_vector_order)
        else $error("reset vector bytes not fetched in order");
endmodule : rcf_vector_fetch

// >>> rcf_reset_flags.sv
// reset-cause flag register and reset sequencer
`timescale 1ns/1ps
module rcf_reset_flags
    import rcf_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        extResetPin_n,
    input  wire logic        watchdogReq,
    input  wire logic        ramParityReq,
    input  wire logic        badAccessReq,
    input  wire logic        powerOnReq,
    input  wire logic        execValid,
    input  wire logic [7:0]  execOpcode,
    input  wire logic        cpuRd,
    input  wire logic [19:0] cpuAddr,
    input  wire logic        cpuByteAcc,
    input  wire logic        cpuBitOp,
    output logic [7:0]       cpuRdData,
    output logic             cpuRdValid,
    output logic             coreReset_n,
    output logic             pcValid,
    output logic [19:0]      programCounter,
    output logic [7:0]       processorStatusWord,
    output logic [19:0]      codeAddr,
    output logic             codeRd,
    input  wire logic [7:0]  codeData,
    output logic             port4Bit0PullUp,
    output logic             port12Bit5Out,
    output logic             port12Bit5Oe,
    output logic             port12Bit5PullUp
);
    typedef struct packed {
        rcf_state_t           st;
        logic [7:0]           flags;
        logic [RCF_CNT_W-1:0] cnt;
        logic [7:0]           rdData;
        logic                 rdValid;
        logic                 coreRstN;
        logic                 pcValid;
        logic [19:0]          pc;
        logic [7:0]           statusWord;
        logic                 fetchStart;
        logic                 p4b0Pull;
        logic                 p12b5Out;
        logic                 p12b5Oe;
        logic                 p12b5Pull;
    } rcf_top_st_t;

    localparam logic [RCF_CNT_W-1:0] HOLD_LOAD =
        RCF_CNT_W'(RCF_HOLD_CYC - 1);
    localparam logic [RCF_CNT_W-1:0] WAIT_LOAD =
        RCF_CNT_W'(RCF_OSC_WAIT_CYC - 1);

    rcf_top_st_t s_r;
    rcf_top_st_t s_nxt;
    logic        extPinSync;
    logic        extLow;
    logic        trapReq;
    logic [7:0]  setVec;
    logic        reqAny;
    logic        rdHit;

    rcf_fetch_if fif ();

    // external pin comes from outside the clock domain
    rcf_sync2 u_sync (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .asyncIn (extResetPin_n),
        .syncOut (extPinSync)
    );

    rcf_vector_fetch u_fetch (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .fif      (fif),
        .codeAddr (codeAddr),
        .codeRd   (codeRd),
        .codeData (codeData)
    );

    // request decoding; internal sources only count while running
    always_comb begin
        extLow  = !extPinSync;
        trapReq = execValid && (execOpcode == RCF_ILLEGAL_OP);
        setVec  = 8'h00;
        if (s_r.st == RCF_ST_RUN) begin
            setVec[RCF_BIT_TRAP]   = trapReq;
            setVec[RCF_BIT_WDOG]   = watchdogReq;
            setVec[RCF_BIT_PARITY] = ramParityReq;
            setVec[RCF_BIT_BADACC] = badAccessReq;
            setVec[RCF_BIT_PWRON]  = powerOnReq;
        end
        reqAny = |setVec;
        // bit instructions and wide accesses are not answered
        rdHit  = cpuRd && (cpuAddr == RCF_FLAGS_ADDR) && cpuByteAcc
                 && !cpuBitOp && (s_r.st == RCF_ST_RUN);
    end

    // next-state logic for flags, sequencer and pins
    always_comb begin
        s_nxt            = s_r;
        s_nxt.rdValid    = 1'b0;
        s_nxt.fetchStart = 1'b0;
        // pins pulled high unless external reset says otherwise
        s_nxt.p4b0Pull   = 1'b1;
        s_nxt.p12b5Oe    = 1'b0;
        s_nxt.p12b5Out   = 1'b1;
        s_nxt.p12b5Pull  = 1'b1;
        // data sampled from the old flags, clear lands on the same edge
        if (rdHit) begin
            s_nxt.rdData  = s_r.flags & RCF_FLAG_MASK;
            s_nxt.rdValid = 1'b1;
            s_nxt.flags   = RCF_FLAGS_RESET;
        end
        // a new request beats a clear in the same cycle; others hold
        s_nxt.flags = s_nxt.flags | setVec;
        case (s_r.st)
            RCF_ST_RUN: begin
                if (reqAny) begin
                    s_nxt.st       = RCF_ST_HOLD;
                    s_nxt.cnt      = HOLD_LOAD;
                    s_nxt.coreRstN = 1'b0;
                    s_nxt.pcValid  = 1'b0;
                end
            end
            RCF_ST_HOLD: begin
                if (s_r.cnt == '0) begin
                    s_nxt.st  = RCF_ST_WAIT;
                    s_nxt.cnt = WAIT_LOAD;
                end else begin
                    s_nxt.cnt = s_r.cnt - RCF_CNT_W'(1);
                end
            end
            RCF_ST_WAIT: begin
                // stabilisation wait; PC stays undefined meanwhile
                if (s_r.cnt == '0) begin
                    s_nxt.st         = RCF_ST_FETCH;
                    s_nxt.fetchStart = 1'b1;
                end else begin
                    s_nxt.cnt = s_r.cnt - RCF_CNT_W'(1);
                end
            end
            RCF_ST_FETCH: begin
                if (fif.done) begin
                    s_nxt.st       = RCF_ST_RUN;
                    s_nxt.pc       = fif.pc;
                    s_nxt.pcValid  = 1'b1;
                    s_nxt.statusWord = RCF_STATUS_RESET;
                    s_nxt.coreRstN = 1'b1;
                end
            end
            default: s_nxt.st = RCF_ST_HOLD;
        endcase
        // external pin low: flags cleared, reset held while it stays low
        if (extLow) begin
            s_nxt.flags      = RCF_FLAGS_RESET;
            s_nxt.st         = RCF_ST_HOLD;
            s_nxt.cnt        = HOLD_LOAD;
            s_nxt.coreRstN   = 1'b0;
            s_nxt.pcValid    = 1'b0;
            s_nxt.rdValid    = 1'b0;
            s_nxt.fetchStart = 1'b0;
            s_nxt.p4b0Pull   = 1'b0;
            s_nxt.p12b5Oe    = 1'b1;
            s_nxt.p12b5Out   = 1'b0;
            s_nxt.p12b5Pull  = 1'b0;
        end
    end

    // rst_n is the retention-voltage reset: it alone clears everything
    // stack pointer, RAM and work registers get no value here
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_r <= '{st: RCF_ST_HOLD, flags: RCF_FLAGS_RESET,
                     cnt: HOLD_LOAD, rdData: 8'h00, rdValid: 1'b0,
                     coreRstN: 1'b0, pcValid: 1'b0, pc: RCF_PC_RESET,
                     statusWord: RCF_STATUS_RESET, fetchStart: 1'b0,
                     p4b0Pull: 1'b0, p12b5Out: 1'b1, p12b5Oe: 1'b0,
                     p12b5Pull: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    // every output except codeAddr and codeRd (driven by u_fetch) is a field of the state register
    assign fif.start           = s_r.fetchStart;
    assign cpuRdData           = s_r.rdData;
    assign cpuRdValid          = s_r.rdValid;
    assign coreReset_n         = s_r.coreRstN;
    assign pcValid             = s_r.pcValid;
    assign programCounter      = s_r.pc;
    assign processorStatusWord = s_r.statusWord;
    assign port4Bit0PullUp     = s_r.p4b0Pull;
    assign port12Bit5Out       = s_r.p12b5Out;
    assign port12Bit5Oe        = s_r.p12b5Oe;
    assign port12Bit5PullUp    = s_r.p12b5Pull;

    property p_read_clears;
        @(posedge mclk) disable iff (!rst_n)
        (rdHit && !reqAny && !extLow) |=>
            (cpuRdValid && s_r.flags == 8'h00
             && cpuRdData == ($past(s_r.flags) & 8'h97));
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("read did not return old flags then clear");

    property p_ext_clears;
        @(posedge mclk) disable iff (!rst_n)
        extLow |=> (s_r.flags == 8'h00 && !coreReset_n);
    endproperty
    a_ext_clears: assert property (p_ext_clears)
        else $error("external reset left a flag set");

    property p_trap_sets;
        @(posedge mclk) disable iff (!rst_n)
        (s_r.st == RCF_ST_RUN && execValid && execOpcode == 8'hff
         && !extLow) |=> (s_r.flags[7] && !coreReset_n);
    endproperty
    a_trap_sets: assert property (p_trap_sets)
        else $error("illegal opcode did not set bit 7 and reset");

    property p_parity_sets;
        @(posedge mclk) disable iff (!rst_n)
        (s_r.st == RCF_ST_RUN && ramParityReq && !extLow)
            |=> s_r.flags[2];
    endproperty
    a_parity_sets: assert property (p_parity_sets)
        else $error("parity reset did not set bit 2");

    property p_pwron_sets;
        @(posedge mclk) disable iff (!rst_n)
        (s_r.st == RCF_ST_RUN && powerOnReq && !extLow) |=> s_r.flags[0];
    endproperty
    a_pwron_sets: assert property (p_pwron_sets)
        else $error("power-on detect reset did not set bit 0");

    property p_others_hold;
        @(posedge mclk) disable iff (!rst_n)
        (reqAny && !rdHit && !extLow) |=>
            ((s_r.flags & ~$past(setVec))
             == ($past(s_r.flags) & ~$past(setVec)));
    endproperty
    a_others_hold: assert property (p_others_hold)
        else $error("internal reset disturbed another flag");

    property p_zero_bits;
        @(posedge mclk) disable iff (!rst_n)
        cpuRdValid |-> (cpuRdData[6:5] == 2'b00 && !cpuRdData[3]);
    endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("unused flag bit read as one");

    property p_pins_ext;
        @(posedge mclk) disable iff (!rst_n)
        extLow |=> (!port4Bit0PullUp && port12Bit5Oe && !port12Bit5Out);
    endproperty
    a_pins_ext: assert property (p_pins_ext)
        else $error("pin state wrong during external reset");

    sequence s_fetch_done;
        (s_r.st == RCF_ST_FETCH && fif.done && !extLow);
    endsequence
    property p_release;
        @(posedge mclk) disable iff (!rst_n)
        s_fetch_done |=> (pcValid && coreReset_n
            && processorStatusWord == 8'h06
            && programCounter == $past(fif.pc));
    endproperty
    a_release: assert property (p_release)
        else $error("release did not load PC and status word");

    property p_pc_undef;
        @(posedge mclk) disable iff (!rst_n)
        !coreReset_n |-> !pcValid;
    endproperty
    a_pc_undef: assert property (p_pc_undef)
        else $error("PC marked valid during reset");

    // a held core must not see its flags move; only the pin may clear them
    property p_state_kept;
        @(posedge mclk) disable iff (!rst_n)
        ($past(rst_n) && !coreReset_n && !$past(coreReset_n)
         && !$past(extLow)) |-> $stable(s_r.flags);
    endproperty
    a_state_kept: assert property (p_state_kept)
        else $error("flags changed while the core was held in reset");
endmodule : rcf_reset_flags

// >>> rcf_code_mem.sv
// code memory model that answers the vector fetch of the reset block
`timescale 1ns/1ps
module rcf_code_mem #(
    parameter logic [7:0] VEC_LO = 8'h3c,
    parameter logic [7:0] VEC_HI = 8'h12
) (
    input  wire logic        mclk,
    input  wire logic [19:0] codeAddr,
    input  wire logic        codeRd,
    output logic [7:0]       codeData
);
    logic [7:0] dataR = 8'h5a;

    // one-cycle read latency; between reads the bus shows the inverse
    // of its last value so a late capture never sees a stale byte
    always_ff @(posedge mclk) begin
        if (codeRd) begin
            case (codeAddr)
                20'h00000: dataR <= VEC_LO;
                20'h00001: dataR <= VEC_HI;
                default:   dataR <= 8'he7;
            endcase
        end else begin
            dataR <= ~dataR;
        end
    end

    assign codeData = dataR;
endmodule : rcf_code_mem

// >>> rcf_reset_flags_tb_top.sv
// self-checking bench for the reset-cause flag block
`timescale 1ns/1ps
module rcf_reset_flags_tb_top;
    import rcf_pkg::*;
    localparam logic [7:0]  VLO   = 8'h3c;
    localparam logic [7:0]  VHI   = 8'h12;
    localparam logic [19:0] EXPPC = {4'h0, VHI, VLO};
    logic mclk, rst_n, extResetPin_n, watchdogReq, ramParityReq;
    logic badAccessReq, powerOnReq, execValid, cpuRd, cpuByteAcc, cpuBitOp;
    logic [7:0] execOpcode, cpuRdData, processorStatusWord, codeData;
    logic [19:0] cpuAddr, programCounter, codeAddr;
    logic cpuRdValid, coreReset_n, pcValid, codeRd, port4Bit0PullUp;
    logic port12Bit5Out, port12Bit5Oe, port12Bit5PullUp;
    int fails, samplesChecked, cycles;
    logic [7:0] bitOf [5];

    rcf_reset_flags uut (.mclk(mclk), .rst_n(rst_n),
        .extResetPin_n(extResetPin_n), .watchdogReq(watchdogReq),
        .ramParityReq(ramParityReq), .badAccessReq(badAccessReq),
        .powerOnReq(powerOnReq), .execValid(execValid),
        .execOpcode(execOpcode), .cpuRd(cpuRd), .cpuAddr(cpuAddr),
        .cpuByteAcc(cpuByteAcc), .cpuBitOp(cpuBitOp),
        .cpuRdData(cpuRdData),
        .cpuRdValid(cpuRdValid), .coreReset_n(coreReset_n),
        .pcValid(pcValid), .programCounter(programCounter),
        .processorStatusWord(processorStatusWord), .codeAddr(codeAddr),
        .codeRd(codeRd), .codeData(codeData),
        .port4Bit0PullUp(port4Bit0PullUp), .port12Bit5Out(port12Bit5Out),
        .port12Bit5Oe(port12Bit5Oe), .port12Bit5PullUp(port12Bit5PullUp));

    rcf_code_mem #(.VEC_LO(VLO), .VEC_HI(VHI)) mem (.mclk(mclk),
        .codeAddr(codeAddr), .codeRd(codeRd), .codeData(codeData));

    // clock, 10 ns period
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic finishTest;
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finishTest

    // hang guard: the whole sequence needs about 1600 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            finishTest();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk20(input logic [19:0] got, input logic [19:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk20

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1

    // one read strobe; answer is looked at on the falling edge half a cycle after the taking edge
    task automatic readReg(input logic byteAcc, input logic bitOp,
                           input logic [19:0] addr, input logic expValid,
                           input logic [7:0] exp);
        @(negedge mclk);
        cpuRd      = 1'b1;
        cpuAddr    = addr;
        cpuByteAcc = byteAcc;
        cpuBitOp   = bitOp;
        @(negedge mclk);
        cpuRd      = 1'b0;
        cpuByteAcc = 1'b1;
        cpuBitOp   = 1'b0;
        chk1(cpuRdValid, expValid);
        if (expValid) begin
            chk8(cpuRdData, exp);
        end
    endtask : readReg

    // waits for the sequencer to run again, then checks post-reset state
    task automatic afterRun;
        int n;
        n = 0;
        while (coreReset_n !== 1'b1 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        chk1(coreReset_n, 1'b1);
        chk1(pcValid, 1'b1);
        chk20(programCounter, EXPPC);
        chk8(processorStatusWord, RCF_STATUS_RESET);
        chk1(port4Bit0PullUp, 1'b1);
        chk1(port12Bit5PullUp, 1'b1);
        chk1(port12Bit5Oe, 1'b0);
        chk1(port12Bit5Out, 1'b1);
    endtask : afterRun

    // one-cycle request from source k, then checks the reset entry
    task automatic pulseSrc(input int k);
        @(negedge mclk);
        case (k)
            0: watchdogReq = 1'b1;
            1: ramParityReq = 1'b1;
            2: badAccessReq = 1'b1;
            3: powerOnReq = 1'b1;
            default: begin
                execValid  = 1'b1;
                execOpcode = RCF_ILLEGAL_OP;
            end
        endcase
        @(negedge mclk);
        {watchdogReq, ramParityReq, badAccessReq, powerOnReq} = 4'h0;
        execValid = 1'b0;
        chk1(coreReset_n, 1'b0);
        chk1(pcValid, 1'b0);
        chk1(port4Bit0PullUp, 1'b1);
        chk1(port12Bit5Oe, 1'b0);
        chk8(processorStatusWord, RCF_STATUS_RESET);
    endtask : pulseSrc

    initial begin
        bitOf = '{8'h10, 8'h04, 8'h02, 8'h01, 8'h80};
        {fails, samplesChecked, cycles} = '0;
        {watchdogReq, ramParityReq, badAccessReq, powerOnReq} = 4'h0;
        {execValid, cpuRd, cpuBitOp} = 3'h0;
        execOpcode = 8'h00;
        cpuAddr = RCF_FLAGS_ADDR;
        cpuByteAcc = 1'b1;
        extResetPin_n = 1'b1;
        rst_n = 1'b0;
        repeat (8) @(negedge mclk);
        chk1(port4Bit0PullUp, 1'b0);
        rst_n = 1'b1;
        afterRun();
        readReg(1'b1, 1'b0, RCF_FLAGS_ADDR, 1'b1, 8'h00);
        // every source alone: own bit, then read clears all
        for (int k = 0; k < 5; k++) begin
            pulseSrc(k);
            afterRun();
            readReg(1'b1, 1'b0, RCF_FLAGS_ADDR, 1'b1,
                    bitOf[k]);
            readReg(1'b1, 1'b0, RCF_FLAGS_ADDR, 1'b1, 8'h00);
        end
        // a second source keeps the first flag; a request in reset is lost
        pulseSrc(0);
        @(negedge mclk);
        ramParityReq = 1'b1;
        @(negedge mclk);
        ramParityReq = 1'b0;
        afterRun();
        pulseSrc(2);
        afterRun();
        // refused accesses leave the flags alone
        readReg(1'b0, 1'b0, RCF_FLAGS_ADDR, 1'b0, 8'h00);
        readReg(1'b1, 1'b1, RCF_FLAGS_ADDR, 1'b0, 8'h00);
        readReg(1'b1, 1'b0, 20'hfffa9, 1'b0, 8'h00);
        readReg(1'b1, 1'b0, RCF_FLAGS_ADDR, 1'b1, 8'h12);
        // an ordinary opcode is no trap
        @(negedge mclk);
        execValid  = 1'b1;
        execOpcode = 8'hfe;
        @(negedge mclk);
        execValid = 1'b0;
        @(negedge mclk);
        chk1(coreReset_n, 1'b1);
        // external pin clears flags, floats one pin and drives the other
        pulseSrc(1);
        afterRun();
        @(negedge mclk);
        extResetPin_n = 1'b0;
        repeat (4) @(negedge mclk);
        chk1(coreReset_n, 1'b0);
        chk1(port4Bit0PullUp, 1'b0);
        chk1(port12Bit5Oe, 1'b1);
        chk1(port12Bit5Out, 1'b0);
        extResetPin_n = 1'b1;
        afterRun();
        readReg(1'b1, 1'b0, RCF_FLAGS_ADDR, 1'b1, 8'h00);
        // retention reset in mid-run clears flags as well
        pulseSrc(3);
        afterRun();
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        chk1(port4Bit0PullUp, 1'b0);
        rst_n = 1'b1;
        afterRun();
        readReg(1'b1, 1'b0, RCF_FLAGS_ADDR, 1'b1, 8'h00);
        finishTest();
    end
endmodule : rcf_reset_flags_tb_top
